// >>> tsbt_pkg.sv
// Constants shared by the touch scan batch timer ends and their link.
// Assumes one 125 MHz clock shared by both ends of the link.
// Functional notes
// - 16-bit config register, zero reset, fields 11:8, 2:0
// - Test mode code selects panel resistance range
// - Codes 1100-1110 reserved; 1111 short-circuit test
// - Delay code picks 0,1,2,4,10,20,40,100 ms
// - Nonzero delay auto-triggers scans by timer
// - Pacing covers XYZ and XY, both modes
// - Host sets autonomous bit, function 0000/0001
// - Autonomous mode starts scan on pen touch
// - After set completes, wait out the delay
// - At expiry, pen present: scan and restart
// - Long scan time dominates over batch delay
// - Delay timer starts when scan launches
// - Host clears autonomous bit for host mode
// - Host writes function only after pen touch
// - Host mode paces while touch stays unbroken
// - Pacing ends on pen lift, stop, reset
// - Autonomous bit hands control to the device
// - Stop bit aborts scan at once, self-clears
package tsbt_pkg;
  localparam int CLK_HZ    = 125_000_000;
  localparam int MS_PER_S  = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  // Device register indices on the link
  localparam logic [1:0] REG_BASE = 2'h0;
  localparam logic [1:0] REG_TB   = 2'h1;
  localparam logic [1:0] REG_FUNC = 2'h2;
  localparam logic [15:0] REG_RST = 16'h0000;

  // Field positions
  localparam int TB_TEST_LSB = 8;
  localparam int TB_TEST_MSB = 11;
  localparam int TB_DLY_MSB  = 2;
  localparam int BASE_AUTO   = 15;
  localparam int BASE_STOP   = 14;

  // Codes
  localparam logic [3:0] FUNC_XYZ    = 4'h0;
  localparam logic [3:0] FUNC_XY     = 4'h1;
  localparam logic [3:0] TEST_RSV_LO = 4'hc;
  localparam logic [3:0] TEST_RSV_HI = 4'he;
  localparam logic [3:0] TEST_SHORT  = 4'hf;

  // Batch delays in ms
  localparam logic [6:0] DLY_MS0 = 7'h00;
  localparam logic [6:0] DLY_MS1 = 7'h01;
  localparam logic [6:0] DLY_MS2 = 7'h02;
  localparam logic [6:0] DLY_MS3 = 7'h04;
  localparam logic [6:0] DLY_MS4 = 7'h0a;
  localparam logic [6:0] DLY_MS5 = 7'h14;
  localparam logic [6:0] DLY_MS6 = 7'h28;
  localparam logic [6:0] DLY_MS7 = 7'h64;

  // Host own register indices and control fields
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_STAT = 2'h1;
  localparam logic [1:0] HREG_RDAT = 2'h2;
  localparam int HC_TEST_LSB = 0;
  localparam int HC_TEST_MSB = 3;
  localparam int HC_DLY_LSB  = 4;
  localparam int HC_DLY_MSB  = 6;
  localparam int HC_AUTO     = 7;
  localparam int HC_XY       = 8;
  localparam int HC_GO       = 9;
  localparam int HC_STOP     = 10;
  localparam int HC_RA_LSB   = 11;
  localparam int HC_RA_MSB   = 12;
  localparam int HC_RD_GO    = 13;

  // Batch delay code to milliseconds
  function automatic logic [6:0] tsbt_delay_ms(input logic [2:0] sel);
    case (sel)
      3'h1:    tsbt_delay_ms = DLY_MS1;
      3'h2:    tsbt_delay_ms = DLY_MS2;
      3'h3:    tsbt_delay_ms = DLY_MS3;
      3'h4:    tsbt_delay_ms = DLY_MS4;
      3'h5:    tsbt_delay_ms = DLY_MS5;
      3'h6:    tsbt_delay_ms = DLY_MS6;
      3'h7:    tsbt_delay_ms = DLY_MS7;
      default: tsbt_delay_ms = DLY_MS0;
    endcase
  endfunction

  function automatic logic tsbt_test_rsv(input logic [3:0] code);
    tsbt_test_rsv = (code >= TEST_RSV_LO) && (code <= TEST_RSV_HI);
  endfunction
endpackage

// >>> tsbt_if.sv
// Register link between the host controller and the scan device.
// Assumes both ends run on the same clock; read data one cycle late.
`timescale 1ns/100ps
`default_nettype none
interface tsbt_if;
  logic        wr;         // Write strobe from host
  logic        rd;         // Read strobe from host
  logic [1:0]  addr;       // Register index
  logic [15:0] wdata;      // Write data
  logic [15:0] rdata;      // Read data, cycle after rd
  logic        pen_touch;  // Device sees a pen touch

  modport dev  (input wr, rd, addr, wdata, output rdata, pen_touch);
  modport host (output wr, rd, addr, wdata, input rdata, pen_touch);
endinterface
`default_nettype wire

// >>> tsbt_delay_timer.sv
// Batch delay timer: millisecond prescaler and millisecond counter.
// Assumes i_restart is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tsbt_delay_timer
  import tsbt_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input  wire logic       i_mclk,     // Clock
  input  wire logic       i_rst_b,    // Async reset, active low
  input  wire logic       i_restart,  // Restart count from zero
  input  wire logic [2:0] i_sel,      // Batch delay code
  output logic            o_expired   // Delay has elapsed
);
  import tsbt_pkg::*;
  localparam int PW = $clog2(CYC_MS + 1);

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [6:0]    ms;
  logic [6:0]    next_ms;
  logic          next_exp;
  logic [6:0]    lim;

  // Count clock periods into milliseconds until the limit
  always_comb begin
    lim      = tsbt_delay_ms(i_sel);
    next_pre = pre;
    next_ms  = ms;
    next_exp = o_expired;
    if (i_restart) begin
      next_pre = '0;
      next_ms  = '0;
      next_exp = (lim == DLY_MS0);
    end else if (!o_expired) begin
      if (lim == DLY_MS0 || ms >= lim) begin
        next_exp = 1'b1; // Delay shortened while running
      end else if (pre == PW'(CYC_MS - 1)) begin
        next_pre = '0;
        next_ms  = ms + 7'h01;
        next_exp = (ms + 7'h01) >= lim;
      end else begin
        next_pre = pre + PW'(1);
      end
    end
  end

  // Idle timer reads as expired so a zero delay never pauses
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre       <= '0;
      ms        <= 7'h00;
      o_expired <= 1'b1;
    end else begin
      pre       <= next_pre;
      ms        <= next_ms;
      o_expired <= next_exp;
    end
  end
endmodule
`default_nettype wire

// >>> tsbt_device.sv
// Scan device end: config registers, scan pacing state machine.
// Assumes the pen pin is asynchronous and i_set_done comes from
// the converter on the same clock, one pulse per finished sample set.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tsbt_device
  import tsbt_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input  wire logic       i_mclk,       // Clock, 125 MHz
  input  wire logic       i_rst_b,      // Async reset, active low
  tsbt_if.dev             lk,           // Link to the host
  input  wire logic       i_pen_raw,    // Pen touch pin, async
  input  wire logic       i_set_done,   // Sample set finished pulse
  output logic            o_scan_start, // Start one sample set
  output logic            o_scan_xy,    // Scan is XY, else XYZ
  output logic            o_conv_power, // Converter powered
  output logic            o_scan_wait,  // Waiting out batch delay
  output logic [3:0]      o_test_mode,  // Connection test mode code
  output logic            o_short_test  // Short-circuit panel test
);
  import tsbt_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ARM  = 4'h2,
    S_SCAN = 4'h4,
    S_WAIT = 4'h8
  } tsbt_dstate_e;

  tsbt_dstate_e state;
  tsbt_dstate_e next_state;
  logic         pen_s1;
  logic         pen;
  logic         auto_mode;
  logic         next_auto_mode;
  logic [2:0]   dly_sel;
  logic [2:0]   next_dly_sel;
  logic [3:0]   next_test_mode;
  logic [1:0]   run;
  logic [1:0]   next_run;
  logic         next_scan_xy;
  logic         next_scan_start;
  logic         next_conv_power;
  logic         next_scan_wait;
  logic         next_short_test;
  logic [15:0]  next_rdata;
  logic         restart;
  logic         expired;
  logic         stop_wr;
  logic         func_wr;
  logic         busy;

  // Pen pin passes two flops before any logic looks at it
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pen_s1 <= 1'b0;
      pen    <= 1'b0;
    end else begin
      pen_s1 <= i_pen_raw;
      pen    <= pen_s1;
    end
  end

  tsbt_delay_timer #(
    .CYC_MS (CYC_MS)
  ) u_timer (
    .i_mclk    (i_mclk),
    .i_rst_b   (i_rst_b),
    .i_restart (restart),
    .i_sel     (dly_sel),
    .o_expired (expired)
  );

  // Link write decode
  assign stop_wr = lk.wr && lk.addr == REG_BASE && lk.wdata[BASE_STOP];
  assign func_wr = lk.wr && lk.addr == REG_FUNC &&
                   (lk.wdata[3:0] == FUNC_XYZ || lk.wdata[3:0] == FUNC_XY);
  assign busy    = (state == S_SCAN) || (state == S_WAIT);

  // Register file: only documented fields are stored
  always_comb begin
    next_auto_mode  = auto_mode;
    next_dly_sel    = dly_sel;
    next_test_mode  = o_test_mode;
    if (lk.wr && lk.addr == REG_BASE) begin
      next_auto_mode = lk.wdata[BASE_AUTO];
    end
    if (lk.wr && lk.addr == REG_TB) begin
      next_dly_sel = lk.wdata[TB_DLY_MSB:0];
      if (!tsbt_test_rsv(lk.wdata[TB_TEST_MSB:TB_TEST_LSB])) begin
        next_test_mode = lk.wdata[TB_TEST_MSB:TB_TEST_LSB];
      end
    end
    next_short_test = (next_test_mode == TEST_SHORT);
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = REG_RST;
    if (lk.rd) begin
      case (lk.addr)
        REG_BASE: begin
          next_rdata[BASE_AUTO] = pen;
          next_rdata[BASE_STOP] = !busy;
        end
        REG_TB: begin
          next_rdata[TB_TEST_MSB:TB_TEST_LSB] = o_test_mode;
          next_rdata[TB_DLY_MSB:0]            = dly_sel;
        end
        REG_FUNC: next_rdata[1:0] = run;
        default:  next_rdata = REG_RST;
      endcase
    end
  end

  // Scan pacing; stop and pen lift end it, reset clears it
  always_comb begin
    next_state      = state;
    next_run        = run;
    next_scan_xy    = o_scan_xy;
    next_scan_start = 1'b0;
    restart         = 1'b0;
    if (stop_wr) begin
      next_state = S_IDLE;
      next_run   = 2'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (func_wr) begin
            next_scan_xy = (lk.wdata[3:0] == FUNC_XY);
            next_run     = next_scan_xy ? 2'h2 : 2'h1;
            if (auto_mode) begin
              next_state = S_ARM;
            end else if (pen) begin
              next_state      = S_SCAN;
              next_scan_start = 1'b1;
              restart         = 1'b1;
            end else begin
              next_run = 2'h0; // Host wrote with no touch
            end
          end
        end
        S_ARM: begin
          if (pen) begin
            next_state      = S_SCAN;
            next_scan_start = 1'b1;
            restart         = 1'b1;
          end
        end
        S_SCAN: begin
          if (i_set_done) begin
            if (!expired) begin
              next_state = S_WAIT;
            end else if (pen) begin
              next_scan_start = 1'b1;
              restart         = 1'b1;
            end else begin
              next_state = auto_mode ? S_ARM : S_IDLE;
              next_run   = auto_mode ? run : 2'h0;
            end
          end
        end
        S_WAIT: begin
          if (!auto_mode && !pen) begin
            next_state = S_IDLE;
            next_run   = 2'h0;
          end else if (expired) begin
            if (pen) begin
              next_state      = S_SCAN;
              next_scan_start = 1'b1;
              restart         = 1'b1;
            end else begin
              next_state = auto_mode ? S_ARM : S_IDLE;
              next_run   = auto_mode ? run : 2'h0;
            end
          end
        end
        default: begin
          next_state = S_IDLE;
          next_run   = 2'h0;
        end
      endcase
    end
    next_conv_power = (next_state == S_SCAN) || (next_state == S_WAIT);
    next_scan_wait  = (next_state == S_WAIT);
  end

  // All state and outputs registered
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state        <= S_IDLE;
      auto_mode    <= 1'b0;
      dly_sel      <= 3'h0;
      o_test_mode  <= 4'h0;
      o_short_test <= 1'b0;
      run          <= 2'h0;
      o_scan_xy    <= 1'b0;
      o_scan_start <= 1'b0;
      o_conv_power <= 1'b0;
      o_scan_wait  <= 1'b0;
      lk.rdata     <= REG_RST;
      lk.pen_touch <= 1'b0;
    end else begin
      state        <= next_state;
      auto_mode    <= next_auto_mode;
      dly_sel      <= next_dly_sel;
      o_test_mode  <= next_test_mode;
      o_short_test <= next_short_test;
      run          <= next_run;
      o_scan_xy    <= next_scan_xy;
      o_scan_start <= next_scan_start;
      o_conv_power <= next_conv_power;
      o_scan_wait  <= next_scan_wait;
      lk.rdata     <= next_rdata;
      lk.pen_touch <= pen;
    end
  end
endmodule
`default_nettype wire

// >>> tsbt_host.sv
// Host end: takes orders from software and drives the device link.
// Assumes software port and link share this clock.
`timescale 1ns/100ps
`default_nettype none
module tsbt_host
  import tsbt_pkg::*;
(
  input  wire logic        i_mclk,   // Clock, 125 MHz
  input  wire logic        i_rst_b,  // Async reset, active low
  input  wire logic [1:0]  i_addr,   // Host register index
  input  wire logic [15:0] i_wdata,  // Write data
  input  wire logic        i_wr,     // Write strobe
  input  wire logic        i_rd,     // Read strobe
  output logic [15:0]      o_rdata,  // Read data, cycle after i_rd
  tsbt_if.host             lk        // Link to the device
);
  import tsbt_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_BASE = 5'h02,
    H_FUNC = 5'h04,
    H_RDA  = 5'h08,
    H_RDB  = 5'h10
  } tsbt_hstate_e;

  tsbt_hstate_e state;
  tsbt_hstate_e next_state;
  logic [8:0]   ctrl;
  logic [8:0]   next_ctrl;
  logic [15:0]  rd_val;
  logic [15:0]  next_rd_val;
  logic         err;
  logic         next_err;
  logic         next_wr;
  logic         next_rd;
  logic [1:0]   next_addr;
  logic [15:0]  next_wdata;
  logic [15:0]  next_rdata;
  logic         ctrl_wr;

  assign ctrl_wr = i_wr && i_addr == HREG_CTRL;

  // Sequencer: config, base, then function, in host mode once pen is seen
  always_comb begin
    next_state  = state;
    next_ctrl   = ctrl;
    next_rd_val = rd_val;
    next_err    = err;
    next_wr     = 1'b0;
    next_rd     = 1'b0;
    next_addr   = lk.addr;
    next_wdata  = lk.wdata;
    if (ctrl_wr && i_wdata[HC_STOP]) begin
      next_state = H_IDLE;
      next_wr    = 1'b1;
      next_addr  = REG_BASE;
      next_wdata = REG_RST;
      next_wdata[BASE_STOP] = 1'b1;
      next_wdata[BASE_AUTO] = ctrl[HC_AUTO];
    end else begin
      case (state)
        H_IDLE: begin
          if (ctrl_wr && i_wdata[HC_GO]) begin
            next_err  = tsbt_test_rsv(i_wdata[HC_TEST_MSB:HC_TEST_LSB]);
            if (!next_err) begin
              next_ctrl  = i_wdata[8:0]; // Refused go keeps the old mode
              next_state = H_BASE;
              next_wr    = 1'b1;
              next_addr  = REG_TB;
              next_wdata = REG_RST;
              next_wdata[TB_TEST_MSB:TB_TEST_LSB] =
                i_wdata[HC_TEST_MSB:HC_TEST_LSB];
              next_wdata[TB_DLY_MSB:0] = i_wdata[HC_DLY_MSB:HC_DLY_LSB];
            end
          end else if (ctrl_wr && i_wdata[HC_RD_GO]) begin
            next_state = H_RDA;
            next_rd    = 1'b1;
            next_addr  = i_wdata[HC_RA_MSB:HC_RA_LSB];
          end
        end
        H_BASE: begin
          next_state = H_FUNC;
          next_wr    = 1'b1;
          next_addr  = REG_BASE;
          next_wdata = REG_RST;
          next_wdata[BASE_AUTO] = ctrl[HC_AUTO];
        end
        H_FUNC: begin
          if (ctrl[HC_AUTO] || lk.pen_touch) begin
            next_state = H_IDLE;
            next_wr    = 1'b1;
            next_addr  = REG_FUNC;
            next_wdata = REG_RST;
            next_wdata[3:0] = ctrl[HC_XY] ? FUNC_XY : FUNC_XYZ;
          end
        end
        H_RDA: next_state = H_RDB;
        H_RDB: begin
          next_rd_val = lk.rdata;
          next_state  = H_IDLE;
        end
        default: next_state = H_IDLE;
      endcase
    end
  end

  // Software read mux, answer one cycle after the strobe
  always_comb begin
    next_rdata = REG_RST;
    if (i_rd) begin
      case (i_addr)
        HREG_CTRL: next_rdata[8:0] = ctrl;
        HREG_STAT: next_rdata[2:0] = {err, lk.pen_touch, state != H_IDLE};
        HREG_RDAT: next_rdata = rd_val;
        default:   next_rdata = REG_RST;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state    <= H_IDLE;
      ctrl     <= 9'h000;
      rd_val   <= REG_RST;
      err      <= 1'b0;
      lk.wr    <= 1'b0;
      lk.rd    <= 1'b0;
      lk.addr  <= REG_BASE;
      lk.wdata <= REG_RST;
      o_rdata  <= REG_RST;
    end else begin
      state    <= next_state;
      ctrl     <= next_ctrl;
      rd_val   <= next_rd_val;
      err      <= next_err;
      lk.wr    <= next_wr;
      lk.rd    <= next_rd;
      lk.addr  <= next_addr;
      lk.wdata <= next_wdata;
      o_rdata  <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> tsbt_link_monitor.sv
// Concurrent checks on the register link between host and scan device.
// Assumes one clock for both ends; sits beside the link in the bench.
`timescale 1ns/100ps
`default_nettype none
module tsbt_link_monitor
  import tsbt_pkg::*;
(
  input  wire logic        i_mclk,    // Clock
  input  wire logic        i_rst_b,   // Async reset, active low
  input  wire logic        i_wr,        // Link write strobe
  input  wire logic        i_rd,        // Link read strobe
  input  wire logic [1:0]  i_addr,      // Register index
  input  wire logic [15:0] i_wdata,     // Write data
  input  wire logic [15:0] i_rdata,     // Read data
  input  wire logic        i_pen_touch  // Synced pen
);
  import tsbt_pkg::*;
  logic [3:0] tst;
  logic [3:0] next_tst;
  logic [2:0] dly;
  logic [2:0] next_dly;
  logic       auto_mode;
  logic       next_auto_mode;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // Shadow of the link registers; reserved test codes leave the field alone
  always_comb begin
    next_tst       = tst;
    next_dly       = dly;
    next_auto_mode = auto_mode;
    if (i_wr && i_addr == REG_TB) begin
      next_dly = i_wdata[2:0];
      if (!(i_wdata[11:10] == 2'h3 && i_wdata[9:8] != 2'h3)) begin
        next_tst = i_wdata[11:8];
      end
    end
    if (i_wr && i_addr == REG_BASE) begin
      next_auto_mode = i_wdata[BASE_AUTO];
    end
  end

  // Shadow flops, cleared with the device
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tst       <= 4'h0;
      dly       <= 3'h0;
      auto_mode <= 1'b0;
    end else begin
      tst       <= next_tst;
      dly       <= next_dly;
      auto_mode <= next_auto_mode;
    end
  end

  a_strobe_excl: assert property (!(i_wr && i_rd))
    else $error("link read and write strobes together");
  a_rdata_quiet: assert property (!$past(i_rd) |-> i_rdata == 16'h0000)
    else $error("link read data outside its cycle");
  a_tb_readback: assert property ($past(i_rd) && $past(i_addr) == REG_TB |->
    i_rdata == {4'h0, $past(tst), 5'h00, $past(dly)})
    else $error("test and delay register readback wrong");
  a_func_onehot: assert property ($past(i_rd) && $past(i_addr) == REG_FUNC |->
    i_rdata[15:2] == 14'h0000 && i_rdata[1:0] != 2'h3)
    else $error("running function readback not one-hot");
  a_base_unused: assert property ($past(i_rd) && $past(i_addr) == REG_BASE |->
    i_rdata[13:0] == 14'h0000)
    else $error("base register unused bits not zero");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 2'h3 |->
    i_rdata == 16'h0000)
    else $error("unmapped register read not zero");
  a_func_code: assert property (i_wr && i_addr == REG_FUNC |->
    i_wdata[3:0] == FUNC_XYZ || i_wdata[3:0] == FUNC_XY)
    else $error("function code neither XYZ nor XY");
  a_func_pen: assert property (i_wr && i_addr == REG_FUNC && !auto_mode |->
    i_pen_touch || $past(i_pen_touch))
    else $error("host-mode function written without pen");
  a_go_order: assert property (i_wr && i_addr == REG_TB |=> i_wr && i_addr == REG_BASE)
    else $error("base write does not follow test and delay write");
  a_stop_auto: assert property (i_wr && i_addr == REG_BASE && i_wdata[BASE_STOP] |->
    i_wdata[BASE_AUTO] == auto_mode)
    else $error("stop write changes autonomous mode");
endmodule
`default_nettype wire

// >>> touch_scan_batch_timer_tb.sv
// Bench: host and device ends joined by the link, converter stood in here.
// Assumes a short millisecond (CMS clocks) so all delay codes run quickly.
`timescale 1ns/100ps
`default_nettype none
module touch_scan_batch_timer_tb;
  import tsbt_pkg::*;
  localparam int CMS = 10;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [1:0]  i_addr = 2'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        pen = 1'b0;
  logic        done = 1'b0;
  logic [15:0] o_rdata;
  logic        o_scan_start, o_scan_xy, o_conv_power, o_scan_wait, o_short_test;
  logic [3:0]  o_test_mode;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          lat = 2;
  int          dcnt = 0;
  int          w_seen = 0;
  int          starts[$];
  int          ms_tab[8] = '{0, 1, 2, 4, 10, 20, 40, 100};
  tsbt_if lnk();

  tsbt_host tsbt_host_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .lk(lnk));
  tsbt_device #(.CYC_MS(CMS)) tsbt_device_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .lk(lnk), .i_pen_raw(pen), .i_set_done(done), .o_scan_start(o_scan_start),
    .o_scan_xy(o_scan_xy), .o_conv_power(o_conv_power), .o_scan_wait(o_scan_wait),
    .o_test_mode(o_test_mode), .o_short_test(o_short_test));
  tsbt_link_monitor tsbt_link_monitor_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wr(lnk.wr),
    .i_rd(lnk.rd), .i_addr(lnk.addr), .i_wdata(lnk.wdata), .i_rdata(lnk.rdata),
    .i_pen_touch(lnk.pen_touch));

  always #4 i_mclk = ~i_mclk;

  // Converter stand-in: one finished set lat cycles after each start
  always @(posedge i_mclk) begin
    done <= 1'b0;
    if (o_scan_start === 1'b1) begin
      dcnt <= lat;
    end else if (dcnt > 0) begin
      dcnt <= dcnt - 1;
      done <= (dcnt == 1);
    end
  end

  // Start times and wait state, sampled mid-cycle where outputs are settled
  always @(negedge i_mclk) begin
    cyc++;
    if (o_scan_start === 1'b1) begin
      starts.push_back(cyc);
    end
    if (o_scan_wait === 1'b1) begin
      w_seen++;
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, got);
    end
  endtask

  function automatic logic [15:0] ctl(input int t, d, a, x, g, s);
    return 16'(t | d << 4 | a << 7 | x << 8 | g << 9 | s << 10);
  endfunction

  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask

  task automatic wait_idle();
    logic [15:0] s;
    for (int k = 0; k < 50; k++) begin
      sw_rd(HREG_STAT, s);
      if (s[0] === 1'b0) break;
    end
  endtask

  task automatic dev_rd(input int a, output logic [15:0] v);
    sw_wr(HREG_CTRL, 16'(a << 11 | 1 << 13));
    wait_idle();
    sw_rd(HREG_RDAT, v);
  endtask

  task automatic wait_n(input int n, input int lim);
    for (int k = 0; k < lim && starts.size() < n; k++) @(posedge i_mclk);
  endtask

  // Paced run: four sets, spacing from delay or from a long converter
  task automatic pace(input int s, input int au, input int xy);
    int dm;
    int ex;
    int g;
    logic [15:0] v;
    dm = ms_tab[s] * CMS;
    lat = (s == 1) ? 25 + $urandom_range(5, 0) : 2 + $urandom_range(5, 0);
    ex = (dm > lat + 2) ? dm : lat + 2;
    @(posedge i_mclk);
    pen <= 1'b1;
    repeat (6) @(posedge i_mclk);
    starts.delete();
    w_seen = 0;
    sw_wr(HREG_CTRL, ctl(0, s, au, xy, 1, 0));
    wait_n(4, 5000);
    chk("sets started", 4, 16'(starts.size()));
    for (int k = 1; k < 4; k++) chk_rng("set spacing", ex, ex + 3, starts[k] - starts[k-1]);
    chk("wait entered", 16'(dm > lat + 1), 16'(w_seen > 0));
    dev_rd(REG_FUNC, v);
    chk("running function", 16'(1 << xy), v);
    chk("scan kind", 16'(xy), 16'(o_scan_xy));
    chk("converter power", 16'h1, 16'(o_conv_power));
    sw_wr(HREG_CTRL, ctl(0, 0, 0, 0, 0, 1));
    repeat (3) @(posedge i_mclk);
    chk("power after stop", 16'h0, 16'(o_conv_power));
    g = starts.size();
    repeat (ex + 20) @(posedge i_mclk);
    chk("sets after stop", 16'(g), 16'(starts.size()));
    wait_idle();
  endtask

  task automatic stop_test();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_errors++;
    $display("unexpected run length: expected finish, seen timeout");
    stop_test();
  end

  initial begin
    logic [15:0] v;
    int mt;
    int md;
    void'($urandom(44219));
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    dev_rd(REG_TB, v);
    chk("reset test and delay", 16'h0000, v);
    dev_rd(REG_BASE, v);
    chk("idle base register", 16'h4000, v);
    dev_rd(3, v);
    chk("unmapped register", 16'h0000, v);
    // Every test code; reserved ones must be refused whole
    mt = 0;
    md = 0;
    for (int c = 0; c < 16; c++) begin
      int d;
      d = $urandom_range(7, 0);
      sw_wr(HREG_CTRL, ctl(c, d, 1, 0, 1, 0));
      wait_idle();
      if (c >= 12 && c <= 14) begin
        sw_rd(HREG_STAT, v);
        chk("reserved code flag", 16'h1, 16'(v[2]));
      end else begin
        mt = c;
        md = d;
      end
      sw_wr(HREG_CTRL, ctl(0, 0, 0, 0, 0, 1));
      wait_idle();
      dev_rd(REG_TB, v);
      chk("test and delay", 16'(mt << 8 | md), v);
      chk("test mode out", 16'(mt), 16'(o_test_mode));
      chk("short test out", 16'(mt == 15), 16'(o_short_test));
    end
    for (int s = 0; s < 8; s++) pace(s, s % 2, s / 2 % 2);
    // Host mode: held back until pen, ends for good on a lift
    lat = 3;
    @(posedge i_mclk);
    pen <= 1'b0;
    repeat (6) @(posedge i_mclk);
    starts.delete();
    sw_wr(HREG_CTRL, ctl(0, 3, 0, 0, 1, 0));
    repeat (30) @(posedge i_mclk);
    chk("sets before pen", 16'h0, 16'(starts.size()));
    pen <= 1'b1;
    wait_n(2, 200);
    pen <= 1'b0;
    repeat (45) @(posedge i_mclk);
    chk("power after lift", 16'h0, 16'(o_conv_power));
    pen <= 1'b1;
    md = starts.size();
    repeat (60) @(posedge i_mclk);
    chk("sets after lift", 16'(md), 16'(starts.size()));
    // Autonomous: armed until pen, re-armed after a lift
    pen <= 1'b0;
    repeat (6) @(posedge i_mclk);
    starts.delete();
    sw_wr(HREG_CTRL, ctl(0, 3, 1, 1, 1, 0));
    repeat (30) @(posedge i_mclk);
    chk("armed sets", 16'h0, 16'(starts.size()));
    pen <= 1'b1;
    wait_n(1, 12);
    pen <= 1'b0;
    repeat (60) @(posedge i_mclk);
    chk("sets after auto lift", 16'h1, 16'(starts.size()));
    pen <= 1'b1;
    wait_n(2, 12);
    chk("sets on new pen", 16'h2, 16'(starts.size()));
    // Reset in mid-scan ends pacing and clears the config register
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("power after reset", 16'h0, 16'(o_conv_power));
    dev_rd(REG_TB, v);
    chk("config after reset", 16'h0000, v);
    sw_wr(HREG_CTRL, ctl(0, 0, 0, 0, 0, 1));
    wait_idle();
    stop_test();
  end
endmodule
`default_nettype wire
